//--- capture_timer.v
// Purpose: 16-bit timer section for pulse-width capture and square-wave output
// Assumes: Single clock; plain register port with read data one cycle later
// Notes:   Interval, event-count, pulse-generator and one-shot modes not built
//
// Design decisions made here: strobed register access and the register offsets.

`timescale 1ns/10ps
`include "capture_timer_defines.vh"

// How it works
// - Widths are measured either off a free-running counter or by capture-and-restart on input A edges.
// - An input level counts only after two equal samples at the count clock, rejecting short noise.
// - In free-running mode each valid edge on input A copies the counter into register B and raises interrupt B.
// - With input B enabled and two-register mode off, a valid edge on input B copies the counter into register A and raises interrupt A.
// - In two-register mode the opposite edge of input A captures into register A while the selected edge loads B.
// - With input A set to both edges, register A never captures from input A.
// - With the capture-source bit set, a B edge raises interrupt A but leaves register A untouched.
// - In restart mode each valid A edge captures into register B and then clears the counter to zero.
// - In clear-on-compare mode with output enable and toggle set, the output pin inverts every compare value plus one count clocks.
// - The counter runs while the mode bits are nonzero and is cleared to zero and held there when they return to zero.
module capture_timer
(
	clock,
	reset,
	clk_en,
	addr,
	wr_data,
	wr_stb,
	rd_stb,
	rd_data,
	timer_input_a,
	timer_input_b,
	timer_output_pin,
	irq_reg_a_event,
	irq_reg_b_event,
	irq
);
	input  wire        clock;
	input  wire        reset;
	input  wire        clk_en;
	input  wire [3:0]  addr;
	input  wire [15:0] wr_data;
	input  wire        wr_stb;
	input  wire        rd_stb;
	output reg  [15:0] rd_data;
	input  wire        timer_input_a;
	input  wire        timer_input_b;
	output reg         timer_output_pin;
	output reg         irq_reg_a_event;
	output reg         irq_reg_b_event;
	output reg         irq;

	// =============================================================
	// Registers
	reg [1:0]  timer_mode_control_ff;
	reg [2:0]  capture_control_ff;
	reg [7:0]  prescaler_edge_select_ff;
	reg [2:0]  output_control_ff;
	reg [15:0] capcomp_reg_a_ff;
	reg [15:0] capcomp_reg_b_ff;
	reg [15:0] count_value_ff;
	reg [2:0]  status_ff;
	reg [2:0]  irq_mask_ff;
	reg        input_a_dly_ff;

	reg [15:0] nxt_count;
	reg [15:0] nxt_cap_a;
	reg [15:0] nxt_cap_b;
	reg        nxt_out;
	reg        ev_a;
	reg        ev_b;
	reg        ev_ovf;
	reg [15:0] nxt_rd;

	wire       run;
	wire       tick;
	wire       a_rise;
	wire       a_fall;
	wire       a_valid;
	wire       b_valid;
	wire       a_opposite;
	wire       a_pin_edge;
	wire [1:0] es_a;
	wire [1:0] es_b;
	wire       wr_mode;
	wire       wr_status;
	wire [2:0] nxt_status;

	assign run   = timer_mode_control_ff != `MODE_STOP;
	assign es_a  = prescaler_edge_select_ff[`ES_A_LO_BIT+1:`ES_A_LO_BIT];
	assign es_b  = prescaler_edge_select_ff[`ES_B_LO_BIT+1:`ES_B_LO_BIT];
	assign wr_mode   = wr_stb && (addr == `OFS_MODE);
	assign wr_status = wr_stb && (addr == `OFS_STATUS);

	// Raw pin edge for the external count clock, outside the capture filter
	assign a_pin_edge = timer_input_a ^ input_a_dly_ff;

	// =============================================================
	// Count clock and input filters
	count_prescaler u_pre
	(
		.clock    (clock),
		.reset    (reset),
		.clk_en   (clk_en),
		.run      (run),
		.clk_sel  (prescaler_edge_select_ff[`PRE_CLK_LO_BIT+1:`PRE_CLK_LO_BIT]),
		.ext_edge (a_pin_edge),
		.tick     (tick)
	);

	edge_filter u_filt_a
	(
		.clock       (clock),
		.reset       (reset),
		.clk_en      (clk_en),
		.sample_tick (tick),
		.pin_in      (timer_input_a),
		.edge_sel    (es_a),
		.rise_out    (a_rise),
		.fall_out    (a_fall),
		.valid_out   (a_valid)
	);

	edge_filter u_filt_b
	(
		.clock       (clock),
		.reset       (reset),
		.clk_en      (clk_en),
		.sample_tick (tick),
		.pin_in      (timer_input_b),
		.edge_sel    (es_b),
		.rise_out    (),
		.fall_out    (),
		.valid_out   (b_valid)
	);

	// Opposite edge of input A; none exists when both edges are selected
	assign a_opposite = ((es_a == `EDGE_RISE) && a_fall) ||
		((es_a == `EDGE_FALL) && a_rise);

	// =============================================================
	// Counter, capture and square-wave logic
	always @*
	begin
		nxt_count = count_value_ff;
		nxt_cap_a = capcomp_reg_a_ff;
		nxt_cap_b = capcomp_reg_b_ff;
		nxt_out   = timer_output_pin;
		ev_a      = 1'b0;
		ev_b      = 1'b0;
		ev_ovf    = 1'b0;
		if (!run)
			nxt_count = `RST_WORD;
		else if (tick)
		begin
			nxt_count = count_value_ff + 16'h0001;
			if (count_value_ff == `COUNT_MAX)
				ev_ovf = 1'b1;
			if (timer_mode_control_ff == `MODE_CLEAR)
			begin
				// Clear on compare A match gives a period of compare + 1 counts
				if (count_value_ff == capcomp_reg_a_ff)
				begin
					nxt_count = `RST_WORD;
					ev_ovf    = 1'b0;
					ev_a      = 1'b1;
					if (output_control_ff[`OUT_EN_BIT] &&
						output_control_ff[`OUT_TOGGLE_BIT])
						nxt_out = ~timer_output_pin;
				end
			end
			else
			begin
				if (a_valid)
				begin
					nxt_cap_b = count_value_ff;
					ev_b      = 1'b1;
					if (timer_mode_control_ff == `MODE_RESTART)
					begin
						nxt_count = `RST_WORD;
						ev_ovf    = 1'b0;
					end
				end
				if (capture_control_ff[`CAP_B_OPP_BIT] && a_opposite)
					nxt_cap_a = count_value_ff;
				else if (!capture_control_ff[`CAP_B_OPP_BIT] &&
					capture_control_ff[`CAP_A_ON_B_BIT] && b_valid)
				begin
					ev_a = 1'b1;
					if (!capture_control_ff[`CAP_SRC_BIT])
						nxt_cap_a = count_value_ff;
				end
			end
		end
		if (!output_control_ff[`OUT_EN_BIT])
			nxt_out = output_control_ff[`OUT_INIT_BIT];
	end

	// Hardware set wins over a write-one clear in the same cycle
	assign nxt_status = (status_ff & ~(wr_status ? wr_data[2:0] : 3'h0)) |
		{ev_ovf, ev_b, ev_a};

	always @*
	begin
		case (addr)
			`OFS_MODE:     nxt_rd = {14'h0000, timer_mode_control_ff};
			`OFS_CAPCTL:   nxt_rd = {13'h0000, capture_control_ff};
			`OFS_PRESCALE: nxt_rd = {8'h00, prescaler_edge_select_ff};
			`OFS_OUTCTL:   nxt_rd = {13'h0000, output_control_ff};
			`OFS_CMP_A:    nxt_rd = capcomp_reg_a_ff;
			`OFS_CMP_B:    nxt_rd = capcomp_reg_b_ff;
			`OFS_COUNT:    nxt_rd = count_value_ff;
			`OFS_STATUS:   nxt_rd = {13'h0000, status_ff};
			`OFS_IRQ_MASK: nxt_rd = {13'h0000, irq_mask_ff};
			default:       nxt_rd = `RST_WORD;
		endcase
	end

	// =============================================================
	// State update
	always @(posedge clock)
	begin
		if (reset)
		begin
			timer_mode_control_ff    <= `MODE_STOP;
			capture_control_ff       <= 3'h0;
			prescaler_edge_select_ff <= `RST_BYTE;
			output_control_ff        <= 3'h0;
			capcomp_reg_a_ff         <= `RST_WORD;
			capcomp_reg_b_ff         <= `RST_WORD;
			count_value_ff           <= `RST_WORD;
			status_ff                <= 3'h0;
			irq_mask_ff              <= 3'h0;
			input_a_dly_ff           <= 1'b0;
			rd_data                  <= `RST_WORD;
			timer_output_pin         <= 1'b0;
			irq_reg_a_event          <= 1'b0;
			irq_reg_b_event          <= 1'b0;
			irq                      <= 1'b0;
		end
		else if (clk_en)
		begin
			input_a_dly_ff   <= timer_input_a;
			count_value_ff   <= nxt_count;
			capcomp_reg_b_ff <= nxt_cap_b;
			timer_output_pin <= nxt_out;
			status_ff        <= nxt_status;
			irq_reg_a_event  <= ev_a;
			irq_reg_b_event  <= ev_b;
			irq              <= |(nxt_status & irq_mask_ff);
			rd_data          <= rd_stb ? nxt_rd : `RST_WORD;
			if (wr_stb && addr == `OFS_CMP_A)
				capcomp_reg_a_ff <= wr_data;
			else
				capcomp_reg_a_ff <= nxt_cap_a;
			if (wr_mode)
				timer_mode_control_ff <= wr_data[`MODE_HI_BIT:`MODE_LO_BIT];
			if (wr_stb && addr == `OFS_CAPCTL)
				capture_control_ff <= wr_data[2:0];
			if (wr_stb && addr == `OFS_PRESCALE)
				prescaler_edge_select_ff <= wr_data[7:0];
			if (wr_stb && addr == `OFS_OUTCTL)
				output_control_ff <= wr_data[2:0];
			if (wr_stb && addr == `OFS_IRQ_MASK)
				irq_mask_ff <= wr_data[2:0];
		end
	end

endmodule // capture_timer

//--- capture_timer_checker.sv
// Purpose: Port-level assertions for capture_timer
// Assumes: Setup is shadowed from register writes
// Notes:   Only the stop and both-edge checks wait until writes have settled
`timescale 1ns/10ps
module capture_timer_checker
(
	input wire logic        clock,
	input wire logic        reset,
	input wire logic        clk_en,
	input wire logic [3:0]  addr,
	input wire logic [15:0] wr_data,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [15:0] rd_data,
	input wire logic        timer_input_a,
	input wire logic        timer_input_b,
	input wire logic        timer_output_pin,
	input wire logic        irq_reg_a_event,
	input wire logic        irq_reg_b_event,
	input wire logic        irq
);
	logic [1:0] mode_ff;
	logic [2:0] cap_ff;
	logic [7:0] pre_ff;
	logic [2:0] mask_ff;
	logic [1:0] age_ff;
	wire        cfg_wr = clk_en && wr_stb && addr <= 4'h3;
	wire        quiet  = mode_ff == 2'h0 && age_ff == 2'h3;
	wire        only_a = cap_ff[0] && pre_ff[5:4] == 2'h3 && pre_ff[7:6] == 2'h2;
	// ==========================================
	// Setup shadow
	always @(posedge clock)
	begin
		if (reset)
		begin
			mode_ff <= 2'h0;
			cap_ff <= 3'h0;
			pre_ff <= 8'h00;
			mask_ff <= 3'h0;
			age_ff <= 2'h0;
		end
		else if (clk_en)
		begin
			if (cfg_wr)
				age_ff <= 2'h0;
			else if (age_ff != 2'h3)
				age_ff <= age_ff + 2'h1;
			if (wr_stb && addr == 4'h0)
				mode_ff <= wr_data[1:0];
			if (wr_stb && addr == 4'h1)
				cap_ff <= wr_data[2:0];
			if (wr_stb && addr == 4'h2)
				pre_ff <= wr_data[7:0];
			if (wr_stb && addr == 4'h8)
				mask_ff <= wr_data[2:0];
		end
	end
	// ==========================================
	// Properties
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	ev_b_pulse_a: assert property (clk_en && irq_reg_b_event |=> !irq_reg_b_event)
		else $error("event B too long");
	ev_a_pulse_a: assert property (clk_en && irq_reg_a_event |=> !irq_reg_a_event)
		else $error("event A too long");
	stop_quiet_a: assert property (quiet |-> !irq_reg_a_event && !irq_reg_b_event)
		else $error("event while stopped");
	pin_frozen_a: assert property (quiet |=> $stable(timer_output_pin))
		else $error("pin moved while stopped");
	both_no_a_a: assert property (age_ff == 2'h3 && only_a && mode_ff != 2'h3 |-> !irq_reg_a_event)
		else $error("register A captured on both edges");
	irq_raise_a: assert property (irq_reg_b_event && mask_ff[1] |=> irq)
		else $error("irq missing after event B");
	irq_drop_a: assert property ($fell(irq) |-> $past(wr_stb) || $past(wr_stb, 2) || $past(reset) || $past(reset, 2))
		else $error("irq dropped without a write");
	rd_idle_a: assert property (clk_en && !rd_stb |=> rd_data == 16'h0000)
		else $error("read data outside read slot");
endmodule // capture_timer_checker

bind capture_timer capture_timer_checker capture_timer_checker_inst
(
	.clock(clock), .reset(reset), .clk_en(clk_en), .addr(addr), .wr_data(wr_data),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .timer_input_a(timer_input_a),
	.timer_input_b(timer_input_b), .timer_output_pin(timer_output_pin),
	.irq_reg_a_event(irq_reg_a_event), .irq_reg_b_event(irq_reg_b_event), .irq(irq)
);

//--- capture_timer_defines.vh
// Purpose: Constants for the pulse-width capture and square-wave timer block
// Assumes: Included by every design file of the block
// Notes:   Offsets are word indices on the plain register port
`ifndef CAPTURE_TIMER_DEFINES_VH
`define CAPTURE_TIMER_DEFINES_VH

// =============================================================
// Register offsets
`define OFS_MODE      4'h0
`define OFS_CAPCTL    4'h1
`define OFS_PRESCALE  4'h2
`define OFS_OUTCTL    4'h3
`define OFS_CMP_A     4'h4
`define OFS_CMP_B     4'h5
`define OFS_COUNT     4'h6
`define OFS_STATUS    4'h7
`define OFS_IRQ_MASK  4'h8

// =============================================================
// Field positions
`define MODE_LO_BIT      0
`define MODE_HI_BIT      1
`define CAP_A_ON_B_BIT   0
`define CAP_SRC_BIT      1
`define CAP_B_OPP_BIT    2
`define PRE_CLK_LO_BIT   0
`define ES_A_LO_BIT      4
`define ES_B_LO_BIT      6
`define OUT_EN_BIT       0
`define OUT_TOGGLE_BIT   1
`define OUT_INIT_BIT     2
`define ST_IRQ_A_BIT     0
`define ST_IRQ_B_BIT     1
`define ST_OVF_BIT       2

// =============================================================
// Operating modes
`define MODE_STOP     2'h0
`define MODE_RESTART  2'h1
`define MODE_FREE     2'h2
`define MODE_CLEAR    2'h3

// =============================================================
// Edge selections and prescaler
`define EDGE_FALL   2'h0
`define EDGE_RISE   2'h1
`define EDGE_NONE   2'h2
`define EDGE_BOTH   2'h3
`define DIV_4_LAST  8'h03
`define DIV_256_LAST 8'hFF

// =============================================================
// Reset values and counter maximum
`define RST_BYTE    8'h00
`define RST_WORD    16'h0000
`define COUNT_MAX   16'hFFFF

`endif

//--- count_prescaler.v
// Purpose: Count-clock enable generator
// Assumes: Select 0 = every clock, 1 = /4, 2 = /256, 3 = input edge
// Notes:   Held in reset while the timer is stopped so the first tick is aligned
`timescale 1ns/10ps
`include "capture_timer_defines.vh"

module count_prescaler
(
	clock,
	reset,
	clk_en,
	run,
	clk_sel,
	ext_edge,
	tick
);
	input  wire       clock;
	input  wire       reset;
	input  wire       clk_en;
	input  wire       run;
	input  wire [1:0] clk_sel;
	input  wire       ext_edge;
	output reg        tick;

	reg [7:0] div_ff;
	reg [7:0] last;

	always @*
	begin
		last = (clk_sel == 2'h1) ? `DIV_4_LAST : `DIV_256_LAST;
		case (clk_sel)
			2'h0:    tick = run;
			2'h3:    tick = run && ext_edge;
			default: tick = run && (div_ff == last);
		endcase
	end

	always @(posedge clock)
	begin
		if (reset)
			div_ff <= 8'h00;
		else if (clk_en)
		begin
			if (!run || div_ff == last)
				div_ff <= 8'h00;
			else
				div_ff <= div_ff + 8'h01;
		end
	end

endmodule // count_prescaler

//--- edge_filter.v
// Purpose: Two-sample level filter and valid-edge detector for one timer input
// Assumes: Input synchronous to clock; sample_tick marks each count clock
// Notes:   A new level counts only once seen on two successive samples
`timescale 1ns/10ps
`include "capture_timer_defines.vh"

module edge_filter
(
	clock,
	reset,
	clk_en,
	sample_tick,
	pin_in,
	edge_sel,
	rise_out,
	fall_out,
	valid_out
);
	input  wire       clock;
	input  wire       reset;
	input  wire       clk_en;
	input  wire       sample_tick;
	input  wire       pin_in;
	input  wire [1:0] edge_sel;
	output wire       rise_out;
	output wire       fall_out;
	output wire       valid_out;

	reg sample_ff;
	reg level_ff;
	reg nxt_level;

	// =============================================================
	// Double-level sampling
	always @*
	begin
		nxt_level = level_ff;
		if (sample_tick && (sample_ff == pin_in))
			nxt_level = pin_in;
	end

	always @(posedge clock)
	begin
		if (reset)
		begin
			sample_ff <= 1'b0;
			level_ff  <= 1'b0;
		end
		else if (clk_en && sample_tick)
		begin
			sample_ff <= pin_in;
			level_ff  <= nxt_level;
		end
	end

	assign rise_out  = clk_en && (nxt_level & ~level_ff);
	assign fall_out  = clk_en && (~nxt_level & level_ff);
	assign valid_out = ((edge_sel == `EDGE_RISE) && rise_out) ||
		((edge_sel == `EDGE_FALL) && fall_out) ||
		((edge_sel == `EDGE_BOTH) && (rise_out || fall_out));

endmodule // edge_filter

//--- pulse_source.sv
// Purpose: Pulse source standing on one timer input pin
// Assumes: start is a one-cycle request; width at least 1
// Notes:   Line idles low between pulses
`timescale 1ns/10ps
module pulse_source
(
	input wire logic        clock,
	input wire logic        start,
	input wire logic [15:0] width,
	output logic            line
);
	logic [15:0] left_ff = 16'h0000;
	initial line = 1'b0;
	// ==========================================
	// Pulse shaping, high for exactly width cycles
	always @(posedge clock)
	begin
		if (start)
		begin
			line <= 1'b1;
			left_ff <= width - 16'h0001;
		end
		else if (left_ff != 16'h0000)
			left_ff <= left_ff - 16'h0001;
		else
			line <= 1'b0;
	end
endmodule // pulse_source

//--- tb_top.sv
// Purpose: Self-checking bench for capture_timer
// Assumes: clk_en held high; pulse inputs idle low
// Notes:   Widths kept short so the run stays brief
`timescale 1ns/10ps
module tb_top;
	logic        clock, reset, clk_en, wr_stb, rd_stb, go_a, go_b, seen, p;
	logic [3:0]  addr;
	logic [15:0] wr_data, width, v1, v2;
	wire  [15:0] rd_data;
	wire         in_a, in_b, pin, ev_a, ev_b, irq;
	integer      errors = 0;
	integer      samples_checked = 0;
	integer      seed = 73915;
	integer      cyc = 0;
	integer      i, n, g, w;

	capture_timer capture_timer_inst
	(
		.clock(clock), .reset(reset), .clk_en(clk_en), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .timer_input_a(in_a),
		.timer_input_b(in_b), .timer_output_pin(pin), .irq_reg_a_event(ev_a),
		.irq_reg_b_event(ev_b), .irq(irq)
	);
	pulse_source src_a (.clock(clock), .start(go_a), .width(width), .line(in_a));
	pulse_source src_b (.clock(clock), .start(go_b), .width(width), .line(in_b));

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// ==========================================
	// Tasks
	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			errors++;
			$display("[FAIL] %0t timeout", $time);
			final_report;
		end
	end
	task check(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		wr_stb <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1;
		d = rd_data;
	endtask
	task pulse(input logic on_b, input logic [15:0] wd);
		@(posedge clock);
		go_a <= !on_b;
		go_b <= on_b;
		width <= wd;
		@(posedge clock);
		go_a <= 1'b0;
		go_b <= 1'b0;
	endtask
	task wait_ev(input logic on_a, input integer lim);
		seen = 1'b0;
		for (i = 0; i < lim && !seen; i++)
		begin
			@(posedge clock);
			#1;
			seen = on_a ? ev_a === 1'b1 : ev_b === 1'b1;
		end
	endtask
	task setup(input logic [15:0] cap, input logic [15:0] pre, input logic [15:0] mode);
		wr(4'h0, 16'h0000);
		wr(4'h7, 16'h0007);
		wr(4'h1, cap);
		wr(4'h2, pre);
		wr(4'h0, mode);
	endtask
	// Waits up to 60 then 80 cycles for two events from one pulse; v1 and v2 hold the two captures
	task measure(input logic on_b, input logic ea1, input logic [3:0] r1,
		input logic ea2, input logic [3:0] r2);
		w = 6 + {$random(seed)} % 40;
		pulse(on_b, w[15:0]);
		wait_ev(ea1, 60);
		rd(r1, v1);
		wait_ev(ea2, 80);
		rd(r2, v2);
	endtask
	// ==========================================
	// Main sequence
	initial
	begin
		reset = 1'b1;
		clk_en = 1'b1;
		addr = 4'h0;
		wr_data = 16'h0000;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		go_a = 1'b0;
		go_b = 1'b0;
		width = 16'h0000;
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		wr(4'h8, 16'h0007);
		for (n = 0; n < 3; n++)
		begin
			setup(16'h0005, 16'h00B0, 16'h0002);
			measure(1'b0, 1'b0, 4'h5, 1'b0, 4'h5);
			check(v2 - v1, w[15:0], "free one reg");
			setup(16'h0001, 16'h00E0, 16'h0002);
			measure(1'b1, 1'b1, 4'h4, 1'b1, 4'h4);
			check(v2 - v1, w[15:0], "two inputs");
			setup(16'h0004, 16'h0090, 16'h0002);
			measure(1'b0, 1'b0, 4'h5, 1'b1, 4'h4);
			check(v2 - v1, w[15:0], "two regs");
			setup(16'h0005, 16'h00B0, 16'h0001);
			measure(1'b0, 1'b0, 4'h5, 1'b0, 4'h5);
			check(v2, w[15:0] - 16'h0001, "restart");
		end
		$display("done: captures");
		wr(4'h0, 16'h0000);
		wr(4'h4, 16'h1234);
		setup(16'h0003, 16'h00E0, 16'h0002);
		pulse(1'b1, 16'h000A);
		wait_ev(1'b1, 60);
		check({15'h0000, seen}, 16'h0001, "source event");
		rd(4'h4, v1);
		check(v1, 16'h1234, "source keeps reg");
		$display("done: source bit");
		for (n = 0; n < 2; n++)
		begin
			setup(16'h0005, 16'h00B0 | n[15:0], 16'h0002);
			pulse(1'b0, 16'h0001 + 16'h0002 * n[15:0]);
			wait_ev(1'b0, 40);
			check({15'h0000, seen}, 16'h0000, "glitch taken");
			pulse(1'b0, 16'h0010);
			wait_ev(1'b0, 40);
			check({15'h0000, seen}, 16'h0001, "pulse lost");
			// Let the trailing edge be taken so no stale level survives the stop
			repeat (40) @(posedge clock);
		end
		$display("done: filter");
		wr(4'h0, 16'h0000);
		rd(4'h6, v1);
		pulse(1'b0, 16'h000A);
		wait_ev(1'b0, 30);
		rd(4'h6, v2);
		check(v2, v1, "stopped count");
		check({15'h0000, seen}, 16'h0000, "stopped event");
		$display("done: stop");
		for (n = 0; n < 2; n++)
		begin
			w = 1 + {$random(seed)} % 30;
			wr(4'h0, 16'h0000);
			wr(4'h2, n[15:0]);
			wr(4'h1, 16'h0000);
			wr(4'h3, 16'h0003);
			wr(4'h4, w[15:0]);
			wr(4'h0, 16'h0003);
			p = pin;
			for (i = 0; i < 900 && pin === p; i++)
			begin
				@(posedge clock);
				#1;
			end
			p = pin;
			for (g = 0; g < 900 && pin === p; g++)
			begin
				@(posedge clock);
				#1;
			end
			check(g[15:0], (w[15:0] + 16'h0001) << (2 * n), "square period");
		end
		$display("done: square");
		wr(4'h8, 16'h0000);
		setup(16'h0005, 16'h00B0, 16'h0002);
		repeat (65540) @(posedge clock);
		rd(4'h7, v1);
		check(v1 & 16'h0004, 16'h0004, "overflow");
		check({15'h0000, irq}, 16'h0000, "masked irq");
		wr(4'h8, 16'h0004);
		rd(4'hF, v2);
		check(v2, 16'h0000, "unmapped");
		check({15'h0000, irq}, 16'h0001, "unmasked irq");
		wr(4'h7, 16'h0004);
		rd(4'h7, v1);
		check(v1 & 16'h0004, 16'h0000, "overflow clear");
		check({15'h0000, irq}, 16'h0000, "irq clear");
		$display("done: interrupt");
		final_report;
	end
endmodule // tb_top
